// ---- design/door_driver_output_control.sv ----
// Output control, mode sequencing, supply lockout and thermal filtering
module door_driver_output_control
	import door_ctrl_pkg::*;
#(
	parameter int READY_DLY = READY_CYC,
	parameter int ACT_DLY   = ACT_CYC,
	parameter int PWM_LO    = STEP_LO_CYC,
	parameter int PWM_HI    = STEP_HI_CYC
) (
	input  wire logic                     mclk,                        // System clock
	input  wire logic                     reset,                       // Synchronous reset
	input  wire logic                     spi_csb,                     // Chip select pin
	input  wire logic                     pwm_input_one,               // First PWM pin
	input  wire logic                     sense_pwm_shared_pin,        // Shared sense/PWM pin
	input  wire logic                     vs_undervoltage,             // Supply low comparator
	input  wire logic                     vs_overvoltage,              // Supply high comparator
	input  wire logic                     overcurrent,                 // Any overcurrent
	input  wire logic                     thermal_warning_raw,         // Warning comparator
	input  wire logic                     thermal_shutdown_raw,        // Shutdown comparator
	input  wire logic                     vcc_good,                    // Logic supply released
	input  wire logic                     active_mode_select,          // Mode bit, 1 active
	input  wire logic                     internal_pwm_source_select,  // 1 internal generator
	input  wire logic [N_LAMP-1:0]        pwm_frequency_select,        // Per lamp rate
	input  wire logic [N_LAMP*DUTY_W-1:0] pwm_duty_value,              // Per lamp duty
	input  wire logic [N_OUT-1:0]         output_pwm_enable,           // Per output PWM on
	input  wire logic [N_OUT-1:0]         output_on_state,             // Programmed on state
	input  wire logic                     supply_fault_recovery_mode,  // 1 latched recovery
	input  wire logic                     status_clear,                // Clear flags pulse
	output logic [N_OUT-1:0]              output_drive,                // Driver command
	output logic                          output_hiz,                  // All stages off
	output logic                          chargepump_output,           // Pump oscillator on
	output logic                          spi_ready,                   // Serial port usable
	output logic                          supply_or_overcurrent_flag,  // Combined flag
	output logic                          supply_low_flag,             // Supply low flag
	output logic                          thermal_warning_flag,        // Filtered warning
	output logic                          thermal_shutdown_flag        // Filtered shutdown
);

	localparam int RDY_W = $clog2(READY_DLY + 1);
	localparam int ACT_W = $clog2(ACT_DLY + 1);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [SY_N-1:0] async_in;
	logic [SY_N-1:0] s1_q;
	logic [SY_N-1:0] s2_q;
	logic [SY_N-1:0] s3_q;
	logic [SY_N-1:0] clean_q;

	assign async_in = {vcc_good, thermal_shutdown_raw, thermal_warning_raw, overcurrent,
		vs_overvoltage, vs_undervoltage, sense_pwm_shared_pin, pwm_input_one, spi_csb};

	always_ff @(posedge mclk) begin
		if (reset) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			s3_q <= SYNC_RST;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	logic csb_prev_q;
	logic csb_rise;

	// A bit moves only once the second and third stage agree
	always_ff @(posedge mclk) begin
		if (reset) begin
			clean_q    <= SYNC_RST;
			csb_prev_q <= 1'b1;
		end else begin
			clean_q    <= (s2_q & s3_q) | (clean_q & (s2_q | s3_q));
			csb_prev_q <= clean_q[SY_CSB];
		end
	end

	assign csb_rise = clean_q[SY_CSB] & ~csb_prev_q;

	// ----------------------------------------------------------------
	// Serial port ready after logic supply release
	// ----------------------------------------------------------------
	logic [RDY_W-1:0] rdy_cnt_q;

	always_ff @(posedge mclk) begin
		if (reset || !clean_q[SY_VCCOK]) begin
			rdy_cnt_q <= '0;
			spi_ready <= 1'b0;
		end else if (rdy_cnt_q == RDY_W'(READY_DLY - 1)) begin
			spi_ready <= 1'b1;
		end else begin
			rdy_cnt_q <= rdy_cnt_q + RDY_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// Mode sequencing
	// ----------------------------------------------------------------
	mode_t            mode_q;
	logic [ACT_W-1:0] act_cnt_q;

	always_ff @(posedge mclk) begin
		if (reset) begin
			mode_q <= MODE_STANDBY;
		end else begin
			unique case (mode_q)
				MODE_STANDBY: begin
					if (csb_rise && active_mode_select) begin
						mode_q <= MODE_STARTING;
					end
				end
				MODE_STARTING: begin
					if (csb_rise && !active_mode_select) begin
						mode_q <= MODE_STANDBY;
					end else if (act_cnt_q == ACT_W'(ACT_DLY - 1)) begin
						mode_q <= MODE_ACTIVE;
					end
				end
				MODE_ACTIVE: begin
					if (csb_rise && !active_mode_select) begin
						mode_q <= MODE_STANDBY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || mode_q != MODE_STARTING) begin
			act_cnt_q <= '0;
		end else begin
			act_cnt_q <= act_cnt_q + ACT_W'(1);
		end
	end

	// Oscillator follows the bit itself so the pump charges during the start delay
	always_ff @(posedge mclk) begin
		if (reset) begin
			chargepump_output <= 1'b0;
		end else begin
			chargepump_output <= active_mode_select;
		end
	end

	// ----------------------------------------------------------------
	// Supply lockout and flags
	// ----------------------------------------------------------------
	// Flags clear only by reset or host, never by supply loss itself
	logic lock_q;
	logic vs_low;

	assign vs_low = clean_q[SY_VSUV];

	always_ff @(posedge mclk) begin
		if (reset) begin
			lock_q <= 1'b0;
		end else if (vs_low) begin
			lock_q <= 1'b1;
		end else if (!supply_fault_recovery_mode) begin
			lock_q <= 1'b0;
		end else if (status_clear) begin
			lock_q <= 1'b0;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (reset) begin
			supply_low_flag            <= 1'b0;
			supply_or_overcurrent_flag <= 1'b0;
		end else begin
			supply_low_flag            <= vs_low | (supply_low_flag & ~status_clear);
			supply_or_overcurrent_flag <= vs_low | clean_q[SY_VSOV] | clean_q[SY_OC]
				| (supply_or_overcurrent_flag & ~status_clear);
		end
	end

	// ----------------------------------------------------------------
	// Thermal filters
	// ----------------------------------------------------------------
	logic [1:0]        th_raw;
	logic [FILT_W-1:0] th_cnt_q [2];
	logic [1:0]        th_hit;

	assign th_raw = {clean_q[SY_TSD], clean_q[SY_TW]};

	always_ff @(posedge mclk) begin
		for (int i = 0; i < 2; i++) begin
			if (reset || !th_raw[i]) begin
				th_cnt_q[i] <= '0;
			end else if (th_cnt_q[i] != FILT_W'(FILT_CYC - 1)) begin
				th_cnt_q[i] <= th_cnt_q[i] + FILT_W'(1);
			end
		end
	end

	assign th_hit[TH_WARN] = th_raw[TH_WARN] && th_cnt_q[TH_WARN] == FILT_W'(FILT_CYC - 1);
	assign th_hit[TH_SHUT] = th_raw[TH_SHUT] && th_cnt_q[TH_SHUT] == FILT_W'(FILT_CYC - 1);

	always_ff @(posedge mclk) begin
		if (reset) begin
			thermal_warning_flag  <= 1'b0;
			thermal_shutdown_flag <= 1'b0;
		end else begin
			thermal_warning_flag  <= th_hit[TH_WARN]
				| (thermal_warning_flag & ~status_clear);
			thermal_shutdown_flag <= th_hit[TH_SHUT]
				| (thermal_shutdown_flag & ~status_clear);
		end
	end

	// ----------------------------------------------------------------
	// PWM sources and output mixing
	// ----------------------------------------------------------------
	logic [N_LAMP-1:0] gen_pwm;
	logic [N_OUT-1:0]  pwm_sig;
	logic              drivers_on;

	for (genvar g = 0; g < N_LAMP; g++) begin : g_lamp
		lamp_pwm_channel #(
			.STEP_LO (PWM_LO),
			.STEP_HI (PWM_HI)
		) u_pwm (
			.mclk     (mclk),
			.reset    (reset),
			.freq_sel (pwm_frequency_select[g]),
			.duty     (pwm_duty_value[g*DUTY_W +: DUTY_W]),
			.pwm_out  (gen_pwm[g])
		);
	end

	// Shared pin is taken as plain logic; sensing must not load it
	always_comb begin
		for (int i = 0; i < N_OUT; i++) begin
			pwm_sig[i] = ROUTE_SHARED[i] ? clean_q[SY_PWM2] : clean_q[SY_PWM_INPUT_ONE];
		end
		for (int g = 0; g < N_LAMP; g++) begin
			if (ROUTE_LAMP[LAMP_FIRST + g] && internal_pwm_source_select) begin
				pwm_sig[LAMP_FIRST + g] = gen_pwm[g];
			end
		end
	end

	assign drivers_on = (mode_q == MODE_ACTIVE) && !lock_q && !vs_low;

	always_ff @(posedge mclk) begin
		if (reset) begin
			output_drive <= '0;
			output_hiz   <= 1'b1;
		end else begin
			output_hiz   <= ~drivers_on;
			output_drive <= drivers_on ? (output_on_state
				& (pwm_sig | ~output_pwm_enable)) : '0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_go_standby;
		csb_rise && !active_mode_select && mode_q != MODE_STANDBY;
	endsequence
	sequence s_idle_after;
		mode_q == MODE_STANDBY ##1 output_hiz;
	endsequence
	property p_thermal_filter;
		$rose(thermal_warning_flag) |-> $past(th_cnt_q[TH_WARN]) == FILT_W'(FILT_CYC - 1);
	endproperty
	a_thermal_filter: assert property (p_thermal_filter)
		else $error("Warning flag set without full filter time");
	property p_shut_filter;
		$rose(thermal_shutdown_flag) |-> $past(th_cnt_q[TH_SHUT]) == FILT_W'(FILT_CYC - 1);
	endproperty
	a_shut_filter: assert property (p_shut_filter)
		else $error("Shutdown flag set with no sustained detection");
	// Ready drops one cycle after the supply does, so look at the supply one cycle back
	property p_ready;
		spi_ready |-> $past(clean_q[SY_VCCOK]) && rdy_cnt_q == RDY_W'(READY_DLY - 1);
	endproperty
	a_ready: assert property (p_ready)
		else $error("Serial ready out of step with supply release");
	property p_act_start;
		csb_rise && active_mode_select && mode_q == MODE_STANDBY |=> mode_q == MODE_STARTING;
	endproperty
	a_act_start: assert property (p_act_start)
		else $error("Activation did not start on chip select rise");
	property p_act_done;
		$rose(mode_q == MODE_ACTIVE) |-> $past(act_cnt_q) == ACT_W'(ACT_DLY - 1);
	endproperty
	a_act_done: assert property (p_act_done)
		else $error("Active mode reached at wrong time");
	property p_deact;
		s_go_standby |=> s_idle_after;
	endproperty
	a_deact: assert property (p_deact)
		else $error("Drivers not disabled after standby request");
	property p_uv_off;
		vs_low |=> output_hiz && output_drive == '0 && supply_low_flag
			&& supply_or_overcurrent_flag;
	endproperty
	a_uv_off: assert property (p_uv_off)
		else $error("Supply low did not force outputs off and flags");
	property p_combined;
		clean_q[SY_OC] || clean_q[SY_VSOV] |=> supply_or_overcurrent_flag;
	endproperty
	a_combined: assert property (p_combined)
		else $error("Combined flag missed an event");
	property p_auto_rec;
		lock_q && !vs_low && !supply_fault_recovery_mode |=> !lock_q;
	endproperty
	a_auto_rec: assert property (p_auto_rec)
		else $error("Automatic recovery did not release outputs");
	property p_latched;
		lock_q && supply_fault_recovery_mode && !status_clear |=> lock_q ##1 output_hiz;
	endproperty
	a_latched: assert property (p_latched)
		else $error("Latched recovery released without host clear");
	property p_pump;
		!active_mode_select [*2] |-> !chargepump_output;
	endproperty
	a_pump: assert property (p_pump)
		else $error("Charge pump running with standby selected");
	property p_mix;
		drivers_on && output_on_state[0] && !output_pwm_enable[0] |=> output_drive[0];
	endproperty
	a_mix: assert property (p_mix)
		else $error("Output without PWM enable not driven from on state");

endmodule // door_driver_output_control

// ---- design/door_ctrl_pkg.sv ----
// Constants, types and timing figures shared by the door driver output control block
// Overview of operation
// - Thermal warning and shutdown detections filtered 10 to 100 us before flags set
// - Serial port ready within 30 us after logic supply undervoltage release
// - Chip select rise with active bit clear disables drivers within 300 us
// - Internal PWM frequency select picks 170 Hz when 0, 225 Hz when 1
// - Internal PWM duty comes from a 7-bit value per lamp output
// - Source select defaults external; set routes internal generator to lamp outputs
// - Fixed PWM input per output; lamps alternate inputs under external source
// - On state is combined with assigned PWM only when PWM enable set
// - Supply low makes all outputs high impedance and sets both supply flags
// - Combined flag set on overcurrent, supply overvoltage or supply undervoltage
// - Recovery bit 0: outputs restore automatically once supply is normal
// - Recovery bit 1: outputs stay off until host clears the status flags
// - Charge pump oscillator off in standby, starts when active bit written 1
// - Control and status contents kept through supply loss while logic powered
package door_ctrl_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 200;
	localparam int CLK_HZ         = 200_000_000;
	localparam int SYNC_LAT       = 4;
	localparam int T_FILT_US      = 10;
	localparam int T_FILT_MAX_US  = 100;
	localparam int FILT_CYC       = T_FILT_US * CLK_MHZ;
	localparam int FILT_W         = $clog2(FILT_CYC + 1);
	localparam int T_READY_US     = 30;
	localparam int READY_CYC      = T_READY_US * CLK_MHZ - SYNC_LAT;
	localparam int T_ACT_TYP_US   = 170;
	localparam int T_ACT_MAX_US   = 440;
	localparam int ACT_CYC        = T_ACT_TYP_US * CLK_MHZ;
	localparam int T_DEACT_MAX_US = 300;

	// ----------------------------------------------------------------
	// Output and PWM layout
	// ----------------------------------------------------------------
	localparam int N_OUT        = 11;
	localparam int N_LAMP       = 4;
	localparam int LAMP_FIRST   = 6;
	localparam int DUTY_W       = 7;
	localparam int PWM_STEPS    = 128;
	localparam int PWM_LO_HZ    = 170;
	localparam int PWM_HI_HZ    = 225;
	localparam int STEP_LO_CYC  = CLK_HZ / (PWM_LO_HZ * PWM_STEPS);
	localparam int STEP_HI_CYC  = CLK_HZ / (PWM_HI_HZ * PWM_STEPS);
	// Bit set: output follows the shared sense/PWM pin under the external source
	localparam logic [N_OUT-1:0] ROUTE_SHARED = 11'h290;
	// Bit set: output may take the internal generator
	localparam logic [N_OUT-1:0] ROUTE_LAMP   = 11'h3c0;

	// ----------------------------------------------------------------
	// Synchroniser bit positions
	// ----------------------------------------------------------------
	localparam int SY_CSB   = 0;
	localparam int SY_PWM_INPUT_ONE  = 1;
	localparam int SY_PWM2  = 2;
	localparam int SY_VSUV  = 3;
	localparam int SY_VSOV  = 4;
	localparam int SY_OC    = 5;
	localparam int SY_TW    = 6;
	localparam int SY_TSD   = 7;
	localparam int SY_VCCOK = 8;
	localparam int SY_N     = 9;
	localparam logic [SY_N-1:0] SYNC_RST = 9'h001;
	localparam int TH_WARN  = 0;
	localparam int TH_SHUT  = 1;

	typedef enum logic [2:0] {
		MODE_STANDBY  = 3'h1,
		MODE_STARTING = 3'h2,
		MODE_ACTIVE   = 3'h4
	} mode_t;

endpackage

// ---- design/lamp_pwm_channel.sv ----
// Internal PWM generator for one lamp output
module lamp_pwm_channel
	import door_ctrl_pkg::*;
#(
	parameter int STEP_LO = STEP_LO_CYC,
	parameter int STEP_HI = STEP_HI_CYC
) (
	input  wire logic              mclk,     // System clock
	input  wire logic              reset,    // Synchronous reset
	input  wire logic              freq_sel, // 0 low rate, 1 high rate
	input  wire logic [DUTY_W-1:0] duty,     // On steps per period
	output logic                   pwm_out   // Generated PWM
);

	localparam int PW = $clog2(STEP_LO + 1);

	logic [PW-1:0]     pre_q;
	logic              step_q;
	logic [DUTY_W-1:0] phase_q;

	// Step enable: period divided into 128 steps of the chosen rate
	always_ff @(posedge mclk) begin
		if (reset) begin
			pre_q  <= '0;
			step_q <= 1'b0;
		end else if (pre_q == '0) begin
			pre_q  <= freq_sel ? PW'(STEP_HI - 1) : PW'(STEP_LO - 1);
			step_q <= 1'b1;
		end else begin
			pre_q  <= pre_q - PW'(1);
			step_q <= 1'b0;
		end
	end

	// Phase wraps at 128, so every period starts afresh
	always_ff @(posedge mclk) begin
		if (reset) begin
			phase_q <= '0;
		end else if (step_q) begin
			phase_q <= phase_q + DUTY_W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pwm_out <= 1'b0;
		end else begin
			pwm_out <= (phase_q < duty);
		end
	end

endmodule // lamp_pwm_channel

// ---- verif/host_link_model.sv ----
// Host side model: chip select frames and the two external PWM pins
module host_link_model (
	output logic spi_csb,              // Chip select, idle high
	output logic pwm_input_one,        // First PWM pin
	output logic sense_pwm_shared_pin  // Shared sense/PWM pin
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T_LINK = 48;

	initial begin
		spi_csb = 1'b1;
		pwm_input_one = 1'b0;
		sense_pwm_shared_pin = 1'b0;
	end

	// Sensing is taken as off, so the shared pin is driven to clean levels
	task automatic set_pins(input logic a, input logic b);
		pwm_input_one <= a;
		sense_pwm_shared_pin <= b;
	endtask

	// One 24-bit frame on the link clock; returns right at the closing chip select rise
	task automatic frame();
		spi_csb <= 1'b0;
		#(24 * T_LINK);
		spi_csb <= 1'b1;
	endtask
endmodule // host_link_model

// ---- verif/testbench.sv ----
// Self-checking bench for the door driver output control block
module testbench import door_ctrl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Shortened counts so the run stays brief
	// ----------------------------------------------------------------
	localparam int RDY = 20;
	localparam int ACT = 50;
	localparam int SLO = 4;
	localparam int SHI = 3;
	logic        mclk, reset, vs_uv, vs_ov, oc, tw_raw, tsd_raw, vcc_good;
	logic        act_sel, int_src, rec_mode, st_clr, hiz, cp, rdy;
	logic        f_comb, f_low, f_tw, f_tsd;
	logic [3:0]  fsel;
	logic [27:0] duty;
	logic [10:0] pwm_en, on_st, drive;
	logic [3:0]  pv;
	wire         csb, p1, p2;
	integer      n_errors, checked, seed, n, r, g, fs;
	int          cnt[4], ed[4], dv[4], st[4];

	host_link_model u_host (.spi_csb(csb), .pwm_input_one(p1), .sense_pwm_shared_pin(p2));

	door_driver_output_control #(.READY_DLY(RDY), .ACT_DLY(ACT), .PWM_LO(SLO), .PWM_HI(SHI))
	u_door_driver_output_control (
		.mclk(mclk), .reset(reset), .spi_csb(csb), .pwm_input_one(p1),
		.sense_pwm_shared_pin(p2), .vs_undervoltage(vs_uv), .vs_overvoltage(vs_ov),
		.overcurrent(oc), .thermal_warning_raw(tw_raw), .thermal_shutdown_raw(tsd_raw),
		.vcc_good(vcc_good), .active_mode_select(act_sel),
		.internal_pwm_source_select(int_src), .pwm_frequency_select(fsel),
		.pwm_duty_value(duty), .output_pwm_enable(pwm_en), .output_on_state(on_st),
		.supply_fault_recovery_mode(rec_mode), .status_clear(st_clr),
		.output_drive(drive), .output_hiz(hiz), .chargepump_output(cp), .spi_ready(rdy),
		.supply_or_overcurrent_flag(f_comb), .supply_low_flag(f_low),
		.thermal_warning_flag(f_tw), .thermal_shutdown_flag(f_tsd));

	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	// ----------------------------------------------------------------
	// Reference model and shared tasks
	// ----------------------------------------------------------------
	function automatic logic [10:0] exp_drive(int a, int b, logic [10:0] on, logic [10:0] en);
		int src;
		exp_drive = '0;
		for (int k = 0; k < 11; k++) begin
			src = ((11'h290 >> k) & 1) ? b : a;
			exp_drive[k] = on[k] & (en[k] ? src[0] : 1'b1);
		end
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic clear_flags();
		@(posedge mclk) st_clr <= 1'b1;
		@(posedge mclk) st_clr <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A hang would otherwise never reach the verdict
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		$display("watchdog expired");
		give_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0;
		checked = 0;
		seed = 32'h68ea;
		{reset, vs_uv, vs_ov, oc, tw_raw, tsd_raw, vcc_good} = 7'h41;
		{act_sel, int_src, rec_mode, st_clr, fsel, duty} = '0;
		{pwm_en, on_st} = '0;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk) vcc_good <= 1'b1;
		#1;
		check("reset_state", {hiz, cp, rdy, f_comb, f_low, f_tw, f_tsd, drive}, 18'h2_0000);
		n = 0;
		while (rdy !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		check("ready_delay", n >= RDY && n <= RDY + 8, 1);
		@(posedge mclk) act_sel <= 1'b1;
		repeat (2) @(posedge mclk);
		check("pump_on", {cp, hiz}, 2'b11);
		u_host.frame();
		n = 0;
		while (hiz !== 1'b0 && n < 200) begin
			@(posedge mclk);
			n++;
		end
		check("activate_delay", n >= ACT && n <= ACT + 12, 1);
		$display("test mode_up done");
		for (r = 0; r < 8; r++) begin
			u_host.set_pins(r[0], r[1]);
			@(posedge mclk) on_st <= 11'($random(seed));
			pwm_en <= 11'($random(seed));
			repeat (8) @(posedge mclk);
			check("drive_ext", drive, exp_drive(r[0], r[1], on_st, pwm_en));
		end
		$display("test external_pwm done");
		for (r = 0; r < 3; r++) begin
			fs = (r == 0) ? 5 : (r == 1) ? 10 : ($random(seed) & 15);
			for (g = 0; g < 4; g++) begin
				dv[g] = (r == 0) ? (g == 0 ? 0 : 127) : ($random(seed) & 127);
				st[g] = fs[g] ? SHI : SLO;
			end
			@(posedge mclk) int_src <= 1'b1;
			on_st <= 11'h7ff;
			pwm_en <= 11'h3c0;
			fsel <= fs[3:0];
			duty <= {dv[3][6:0], dv[2][6:0], dv[1][6:0], dv[0][6:0]};
			repeat (1536) @(posedge mclk);
			for (g = 0; g < 4; g++) begin
				cnt[g] = 0;
				ed[g] = 0;
				pv[g] = drive[6 + g];
			end
			repeat (1536) begin
				@(posedge mclk);
				for (g = 0; g < 4; g++) begin
					cnt[g] += drive[6 + g];
					ed[g] += (drive[6 + g] & !pv[g]);
					pv[g] = drive[6 + g];
				end
			end
			for (g = 0; g < 4; g++) begin
				check("pwm_on_time", cnt[g], 12 * dv[g]);
				check("pwm_periods", ed[g], dv[g] == 0 ? 0 : 1536 / (128 * st[g]));
			end
		end
		@(posedge mclk) int_src <= 1'b0;
		pwm_en <= 11'($random(seed));
		$display("test internal_pwm done");
		for (r = 0; r < 2; r++) begin
			@(posedge mclk) rec_mode <= r[0];
			vs_uv <= 1'b1;
			repeat (10) @(posedge mclk);
			check("lock_out", {hiz, drive}, 12'h800);
			check("lock_flags", {f_comb, f_low}, 2'b11);
			vs_uv <= 1'b0;
			repeat (20) @(posedge mclk);
			check("recover_hiz", hiz, r[0]);
			check("flag_kept", f_low, 1);
			clear_flags();
			check("after_clear", {hiz, f_comb, f_low}, 0);
			check("drive_back", drive, exp_drive(1, 1, on_st, pwm_en));
		end
		for (r = 0; r < 2; r++) begin
			@(posedge mclk) vs_ov <= !r[0];
			oc <= r[0];
			repeat (10) @(posedge mclk);
			check("combined_flag", {f_comb, f_low, hiz}, 3'b100);
			vs_ov <= 1'b0;
			oc <= 1'b0;
			repeat (6) @(posedge mclk);
			clear_flags();
			check("combined_clear", f_comb, 0);
		end
		$display("test supply done");
		@(posedge mclk) tw_raw <= 1'b1;
		tsd_raw <= 1'b1;
		repeat (1500) @(posedge mclk);
		tw_raw <= 1'b0;
		tsd_raw <= 1'b0;
		repeat (10) @(posedge mclk);
		check("short_thermal", {f_tw, f_tsd}, 2'b00);
		tw_raw <= 1'b1;
		tsd_raw <= 1'b1;
		n = 0;
		while (f_tw !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		check("filter_time", n >= 2000 && n <= 2012, 1);
		check("shutdown_flag", f_tsd, 1);
		tw_raw <= 1'b0;
		tsd_raw <= 1'b0;
		repeat (6) @(posedge mclk);
		clear_flags();
		$display("test thermal done");
		@(posedge mclk) act_sel <= 1'b0;
		repeat (2) @(posedge mclk);
		check("pump_off", cp, 0);
		u_host.frame();
		n = 0;
		while (hiz !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		check("deactivate_delay", n <= 12, 1);
		$display("test mode_down done");
		give_verdict();
	end
endmodule // testbench
